// ### bus_seq_pkg.sv
// Shared constants and types of the external bus cycle sequencer
`default_nettype none
package bus_seq_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CS_NUM = 4;
  // ----------------------------------------------------------------
  // Phase limits in system clock periods
  // ----------------------------------------------------------------
  localparam int AB_MAX = 5;
  localparam int E_MAX = 32;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] AB_BASE = 5'h01;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  // Cycle phases, idle between cycles
  typedef enum logic [2:0] {ph_idle, ph_ab, ph_c, ph_d, ph_e, ph_f} phase_t;
endpackage
`default_nettype wire

// ### sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none
module sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Stage one feeds stage two only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Filter: a level counts only when two stages agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dout <= RST_VAL;
    else if (s2_q == s3_q)
      dout <= s3_q;
  end
endmodule
`default_nettype wire

// ### clk_out_gen.sv
// Reference clock output built from the system clock with a driver enable
`default_nettype none
module clk_out_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire logic enable,
  // Pin side
  output logic bus_reference_clock,
  output logic clk_drv_oe_n
);
  logic pos_q;
  logic neg_q;
  logic en_q;
  // Rising edge toggles, so the XOR follows the clock while enabled
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pos_q <= 1'b0;
      en_q <= 1'b0;
      clk_drv_oe_n <= 1'b1;
    end
    else
    begin
      en_q <= enable;
      clk_drv_oe_n <= !enable;
      if (en_q)
        pos_q <= !pos_q;
    end
  end
  // Falling edge catches up, so the XOR falls with the clock
  always_ff @(negedge mclk or negedge resetn)
  begin
    if (!resetn)
      neg_q <= 1'b0;
    else
      neg_q <= pos_q;
  end
  // Two flops, no gate on the clock itself, so no glitch on enable
  assign bus_reference_clock = pos_q ^ neg_q;
  a_clk_drive: assert property (@(posedge mclk) disable iff (!resetn)
    enable |=> !clk_drv_oe_n) else $error("clock driver not enabled");
endmodule
`default_nettype wire

// ### bus_cycle_seq.sv
// External bus cycle sequencer: five-phase cycles, ready handshake, mux/demux pins
//
// Overview of operation
// - Cycles run AB, C, D, E, F in order
// - Phase lengths come from per-chip-select settings
// - AB is 1-2 periods, plus 0-3 on window change
// - C 0-3, D 0-1, E 1-32, F 0-3
// - Ready, when enabled, holds the access phase
// - Read data caught on the strobe-rising edge
// - Early address changes never disturb captured data
// - System clock drives the reference clock pin
// - Ready polarity is selectable
// - Asynchronous ready goes through a synchroniser
// - Ready inactive waits, active ends the access phase
`default_nettype none
module bus_cycle_seq #(
  parameter int N_CS = bus_seq_pkg::CS_NUM
) (
  // Clocks and reset
  input wire logic mclk,
  input wire logic req_clk,
  input wire logic resetn,
  // Request side, req_clk domain
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [$clog2(N_CS)-1:0] req_cs,
  input wire logic [bus_seq_pkg::ADDR_W-1:0] req_addr,
  input wire logic [bus_seq_pkg::DATA_W-1:0] req_wdata,
  input wire logic req_high_byte,
  output logic req_ready,
  output logic rsp_valid,
  output logic [bus_seq_pkg::DATA_W-1:0] rsp_rdata,
  // Chip select timing settings, static, mclk domain
  input wire logic [N_CS-1:0] cfg_ab_len,
  input wire logic [2*N_CS-1:0] cfg_ab_ext,
  input wire logic [2*N_CS-1:0] cfg_c_len,
  input wire logic [N_CS-1:0] cfg_d_len,
  input wire logic [5*N_CS-1:0] cfg_e_len,
  input wire logic [2*N_CS-1:0] cfg_f_len,
  input wire logic [N_CS-1:0] cfg_mux,
  input wire logic [N_CS-1:0] cfg_rdy_en,
  input wire logic [N_CS-1:0] cfg_rdy_pol,
  input wire logic [N_CS-1:0] cfg_rdy_async,
  input wire logic bus_reference_clock_en,
  // Bus pins
  input wire logic ready_pin,
  input wire logic [bus_seq_pkg::DATA_W-1:0] separate_data_lines_i,
  output logic [bus_seq_pkg::DATA_W-1:0] separate_data_lines_o,
  output logic separate_data_lines_oe_n,
  input wire logic [bus_seq_pkg::DATA_W-1:0] shared_addr_data_lines_i,
  output logic [bus_seq_pkg::DATA_W-1:0] shared_addr_data_lines_o,
  output logic shared_addr_data_lines_oe_n,
  output logic [bus_seq_pkg::ADDR_W-1:0] separate_address_lines,
  output logic [N_CS-1:0] cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic addr_latch_en,
  output logic high_byte_enable_n,
  output logic bus_reference_clock,
  output logic clk_drv_oe_n
);
  localparam int SW = $clog2(N_CS);
  localparam int AW = bus_seq_pkg::ADDR_W;
  localparam int DW = bus_seq_pkg::DATA_W;
  // Refused at elaboration: the select index and field slices assume 2 to 16
  if (N_CS < 2 || N_CS > 16)
    $error("N_CS must lie between 2 and 16");

  // ----------------------------------------------------------------
  // Request side (req_clk): toggle handshake toward mclk
  // ----------------------------------------------------------------
  logic tog_q; // Flips once per request
  logic ack_s; // Acknowledge toggle, synchronised
  logic wr_q;
  logic [SW-1:0] sel_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic hb_q;
  logic [DW-1:0] rdata_q; // mclk side, stable once ack flips
  // Fields stay frozen while a request is in flight, so mclk may read them
  always_ff @(posedge req_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tog_q <= 1'b0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= bus_seq_pkg::DATA_RST;
      wr_q <= 1'b0;
      sel_q <= '0;
      addr_q <= bus_seq_pkg::ADDR_RST;
      wdata_q <= bus_seq_pkg::DATA_RST;
      hb_q <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (req_valid && req_ready)
      begin
        tog_q <= !tog_q;
        req_ready <= 1'b0;
        wr_q <= req_write;
        sel_q <= req_cs;
        addr_q <= req_addr;
        wdata_q <= req_wdata;
        hb_q <= req_high_byte;
      end
      else if (!req_ready && ack_s == tog_q)
      begin
        // Cycle done on the bus side
        req_ready <= 1'b1;
        rsp_valid <= 1'b1;
        rsp_rdata <= rdata_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossings and ready input
  // ----------------------------------------------------------------
  logic req_s; // Request toggle seen in mclk
  logic ack_q; // Last request served, mclk
  logic rdy_async_s; // Ready through the synchroniser
  logic rdy_sync_q; // Ready sampled once, for synchronous use
  sync3 u_req_sync (.clk(mclk), .resetn(resetn), .din(tog_q), .dout(req_s));
  sync3 u_ack_sync (.clk(req_clk), .resetn(resetn), .din(ack_q), .dout(ack_s));
  sync3 u_rdy_sync (.clk(mclk), .resetn(resetn), .din(ready_pin), .dout(rdy_async_s));
  // Synchronous ready is timed to the reference clock, one stage suffices
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdy_sync_q <= 1'b0;
    else
      rdy_sync_q <= ready_pin;
  end

  // ----------------------------------------------------------------
  // Phase sequencer (mclk)
  // ----------------------------------------------------------------
  bus_seq_pkg::phase_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d; // Periods left in phase, minus one
  logic [SW-1:0] cur_q, cur_d; // Chip select of running cycle
  logic cwr_q, cwr_d; // Running cycle is a write
  logic win_vld_q; // A previous window is known
  logic [SW-1:0] win_q; // Last window used
  logic start;
  logic e_end;
  logic rdy_ok;
  logic [4:0] ab_len;
  logic [1:0] c_len;
  logic d_len;
  logic [1:0] f_len;

  // Phase order, skipping zero-length phases
  function automatic bus_seq_pkg::phase_t next_ph(input bus_seq_pkg::phase_t p,
    input logic [1:0] c, input logic d, input logic [1:0] f);
    bus_seq_pkg::phase_t r;
    r = bus_seq_pkg::ph_idle;
    case (p)
      bus_seq_pkg::ph_ab: r = (c != 2'h0) ? bus_seq_pkg::ph_c :
                              d ? bus_seq_pkg::ph_d : bus_seq_pkg::ph_e;
      bus_seq_pkg::ph_c: r = d ? bus_seq_pkg::ph_d : bus_seq_pkg::ph_e;
      bus_seq_pkg::ph_d: r = bus_seq_pkg::ph_e;
      bus_seq_pkg::ph_e: r = (f != 2'h0) ? bus_seq_pkg::ph_f : bus_seq_pkg::ph_idle;
      default: r = bus_seq_pkg::ph_idle;
    endcase
    return r;
  endfunction

  // Per chip select lengths; AB grows only when the window moves
  always_comb
  begin
    c_len = cfg_c_len[2*cur_d +: 2];
    d_len = cfg_d_len[cur_d];
    f_len = cfg_f_len[2*cur_d +: 2];
    ab_len = bus_seq_pkg::AB_BASE + {4'h0, cfg_ab_len[sel_q]};
    if (!win_vld_q || win_q != sel_q)
      ab_len = ab_len + {3'h0, cfg_ab_ext[2*sel_q +: 2]};
  end

  // Ready check: polarity and path per chip select
  always_comb
  begin
    rdy_ok = 1'b1;
    if (cfg_rdy_en[cur_q])
      rdy_ok = (cfg_rdy_async[cur_q] ? rdy_async_s : rdy_sync_q)
               == cfg_rdy_pol[cur_q];
  end

  // Next phase and count
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    cur_d = cur_q;
    cwr_d = cwr_q;
    start = 1'b0;
    e_end = 1'b0;
    if (st_q == bus_seq_pkg::ph_idle)
    begin
      if (req_s != ack_q)
      begin
        start = 1'b1;
        cur_d = sel_q;
        cwr_d = wr_q;
      end
    end
    if (start)
    begin
      st_d = bus_seq_pkg::ph_ab;
      cnt_d = ab_len - 5'h01;
    end
    else if (st_q != bus_seq_pkg::ph_idle && cnt_q != bus_seq_pkg::CNT_ZERO)
      cnt_d = cnt_q - 5'h01;
    else if (st_q == bus_seq_pkg::ph_e && !rdy_ok)
      cnt_d = bus_seq_pkg::CNT_ZERO; // wait state
    else if (st_q != bus_seq_pkg::ph_idle)
    begin
      e_end = (st_q == bus_seq_pkg::ph_e);
      st_d = next_ph(st_q, c_len, d_len, f_len);
      case (st_d)
        bus_seq_pkg::ph_c: cnt_d = {3'h0, c_len} - 5'h01;
        bus_seq_pkg::ph_e: cnt_d = cfg_e_len[5*cur_q +: 5];
        bus_seq_pkg::ph_f: cnt_d = {3'h0, f_len} - 5'h01;
        default: cnt_d = bus_seq_pkg::CNT_ZERO;
      endcase
    end
  end

  // State, window tracking and acknowledge
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= bus_seq_pkg::ph_idle;
      cnt_q <= bus_seq_pkg::CNT_ZERO;
      cur_q <= '0;
      cwr_q <= 1'b0;
      win_vld_q <= 1'b0;
      win_q <= '0;
      ack_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cur_q <= cur_d;
      cwr_q <= cwr_d;
      if (start)
      begin
        win_vld_q <= 1'b1;
        win_q <= sel_q;
      end
      if (st_q != bus_seq_pkg::ph_idle && st_d == bus_seq_pkg::ph_idle)
        ack_q <= req_s;
    end
  end

  // Read data: caught on the edge that raises the strobe; later address
  // moves come after this edge and cannot reach the register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= bus_seq_pkg::DATA_RST;
    else if (e_end && !cwr_q)
      rdata_q <= cfg_mux[cur_q] ? shared_addr_data_lines_i : separate_data_lines_i;
  end

  // ----------------------------------------------------------------
  // Pin outputs, registered from the next phase
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_n <= '1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      addr_latch_en <= 1'b0;
      high_byte_enable_n <= 1'b1;
      separate_address_lines <= bus_seq_pkg::ADDR_RST;
      separate_data_lines_o <= bus_seq_pkg::DATA_RST;
      separate_data_lines_oe_n <= 1'b1;
      shared_addr_data_lines_o <= bus_seq_pkg::DATA_RST;
      shared_addr_data_lines_oe_n <= 1'b1;
    end
    else
    begin
      cs_n <= '1;
      if (st_d != bus_seq_pkg::ph_idle)
        cs_n[cur_d] <= 1'b0;
      rd_n <= !(st_d == bus_seq_pkg::ph_e && !cwr_d);
      wr_n <= !(st_d == bus_seq_pkg::ph_e && cwr_d);
      addr_latch_en <= (st_d == bus_seq_pkg::ph_ab) && cfg_mux[cur_d];
      high_byte_enable_n <= !((st_d != bus_seq_pkg::ph_idle) && hb_q);
      if (start)
        separate_address_lines <= addr_q;
      // Demux data lines: driven for writes from D onward; the request-side
      // word is only frozen inside a cycle, so idle periods keep the last one
      if (cwr_d && st_d != bus_seq_pkg::ph_idle)
        separate_data_lines_o <= wdata_q;
      separate_data_lines_oe_n <= !(cwr_d && !cfg_mux[cur_d] &&
        (st_d == bus_seq_pkg::ph_d || st_d == bus_seq_pkg::ph_e ||
         st_d == bus_seq_pkg::ph_f));
      // Mux lines: address in AB and C, then write data or released
      if (st_d == bus_seq_pkg::ph_ab || st_d == bus_seq_pkg::ph_c)
      begin
        shared_addr_data_lines_o <= addr_q[DW-1:0];
        shared_addr_data_lines_oe_n <= !cfg_mux[cur_d];
      end
      else if (st_d == bus_seq_pkg::ph_idle)
        shared_addr_data_lines_oe_n <= 1'b1;
      else
      begin
        shared_addr_data_lines_o <= wdata_q;
        shared_addr_data_lines_oe_n <= !(cfg_mux[cur_d] && cwr_d);
      end
    end
  end

  clk_out_gen u_clk_out (
    .mclk(mclk),
    .resetn(resetn),
    .enable(bus_reference_clock_en),
    .bus_reference_clock(bus_reference_clock),
    .clk_drv_oe_n(clk_drv_oe_n)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [5:0] run_q; // Periods spent in the current phase, saturating
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      run_q <= 6'h00;
    else if (st_d != st_q || start)
      run_q <= 6'h00;
    else if (run_q != 6'h3f)
      run_q <= run_q + 6'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_phase_order: assert property (st_q == bus_seq_pkg::ph_d && $changed(st_q)
    |-> $past(st_q) inside {bus_seq_pkg::ph_ab, bus_seq_pkg::ph_c})
    else $error("D entered out of order");
  a_ab_length: assert property (st_q == bus_seq_pkg::ph_ab
    |-> run_q < bus_seq_pkg::AB_MAX) else $error("address setup too long");
  a_e_minimum: assert property (st_q == bus_seq_pkg::ph_e && st_d != bus_seq_pkg::ph_e
    |-> run_q >= {1'b0, cfg_e_len[5*cur_q +: 5]}) else $error("access too short");
  a_ready_wait: assert property (st_q == bus_seq_pkg::ph_e && cnt_q == 5'h00 && !rdy_ok
    |=> st_q == bus_seq_pkg::ph_e) else $error("access ended without ready");
  a_ready_end: assert property (st_q == bus_seq_pkg::ph_e && cnt_q == 5'h00 && rdy_ok
    |=> st_q != bus_seq_pkg::ph_e && rd_n && wr_n) else $error("ready ignored");
  a_read_latch: assert property ($rose(rd_n) |-> rdata_q == (cfg_mux[cur_q] ?
    $past(shared_addr_data_lines_i) : $past(separate_data_lines_i)))
    else $error("read data not caught at strobe rise");
  a_cs_span: assert property ((st_q == bus_seq_pkg::ph_idle) == (&cs_n))
    else $error("chip select not spanning cycle");
  a_ale_mux: assert property (addr_latch_en |-> st_q == bus_seq_pkg::ph_ab
    && cfg_mux[cur_q]) else $error("latch enable outside address setup");
  a_mux_release: assert property (st_q == bus_seq_pkg::ph_e && !cwr_q
    |-> shared_addr_data_lines_oe_n) else $error("mux lines driven during read");
  c_write: cover property (!wr_n ##1 wr_n);
  c_read: cover property (!rd_n ##1 rd_n);
  c_ready_wait: cover property (st_q == bus_seq_pkg::ph_e && cnt_q == 5'h00 && !rdy_ok);
  c_window: cover property (start && win_vld_q && win_q != sel_q);
endmodule
`default_nettype wire

// ### ext_mem_model.sv
// Behavioural external memory with a ready handshake, far side of the bus
`default_nettype none
module ext_mem_model (
  // Clock
  input wire logic mclk,
  // Mode and ready behaviour of the selected device
  input wire logic mux,
  input wire logic rdy_pol,
  input wire logic [3:0] rdy_wait,
  // Bus pins seen from the memory
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic addr_latch_en,
  input wire logic [23:0] separate_address_lines,
  input wire logic [15:0] separate_data_lines_o,
  input wire logic [15:0] shared_addr_data_lines_o,
  output logic [15:0] separate_data_lines_i,
  output logic [15:0] shared_addr_data_lines_i,
  output logic ready_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16]; // Word store, low address nibble selects
  logic [3:0] lat_addr = 4'h0; // Address caught while latch enable is high
  logic [3:0] wait_cnt = 4'h0; // Strobe-low periods seen so far
  logic [15:0] last_rd = 16'h0000; // Last word put on the lines
  logic [3:0] idx;
  // ----------------------------------------------------------------
  // Storage and latching
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'ha500 + 16'(i);
  end
  assign idx = mux ? lat_addr : separate_address_lines[3:0];
  // Latch, write capture and wait counting on the system clock
  always @(posedge mclk)
  begin
    if (addr_latch_en)
      lat_addr <= shared_addr_data_lines_o[3:0];
    if (!wr_n)
      mem[idx] <= mux ? shared_addr_data_lines_o : separate_data_lines_o;
    if (!rd_n)
      last_rd <= mem[idx];
    if (rd_n && wr_n)
      wait_cnt <= 4'h0;
    else if (wait_cnt != 4'hf)
      wait_cnt <= wait_cnt + 4'h1;
  end
  // Data only while the read strobe is low; after it rises the lines
  // show the inverse so a late capture cannot pass by luck
  assign separate_data_lines_i = !rd_n ? mem[idx] : ~last_rd;
  assign shared_addr_data_lines_i = separate_data_lines_i;
  // Ready goes active after the set wait and drops when the strobe ends
  assign ready_pin = (!(rd_n && wr_n) && wait_cnt >= rdy_wait) ? rdy_pol : ~rdy_pol;
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the external bus cycle sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic req_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_cs = 2'h0;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_high_byte = 1'b0;
  logic [3:0] cfg_ab_len = 4'h0, cfg_d_len = 4'h0, cfg_mux = 4'h0;
  logic [3:0] cfg_rdy_en = 4'h0, cfg_rdy_pol = 4'h0, cfg_rdy_async = 4'h0;
  logic [7:0] cfg_ab_ext = 8'h00, cfg_c_len = 8'h00, cfg_f_len = 8'h00;
  logic [19:0] cfg_e_len = 20'h00000;
  logic bus_reference_clock_en = 1'b0;
  logic [3:0] mdl_wait = 4'h3; // Memory's ready delay
  logic req_ready, rsp_valid, ready_pin, rd_n, wr_n, addr_latch_en, hbe_n, ref_clk, drv_oe_n;
  logic [15:0] rsp_rdata, sd_i, sd_o, ad_i, ad_o;
  logic [23:0] sep_addr;
  logic [3:0] cs_n, cs_seen;
  logic sd_oe_n, ad_oe_n; // Data line driver enables, low while driving
  // Expected phase settings per chip select
  int ab_a[4], ext_a[4], c_a[4], d_a[4], e_a[4], f_a[4];
  // Bus monitor counts, in mclk periods
  int cs_len, pre_len, stb_len, ale_len, hb_len, stb_sync, sd_len, ad_len;
  int fail_count = 0;
  int check_count = 0;
  // ----------------------------------------------------------------
  // Clocks, phases unrelated
  // ----------------------------------------------------------------
  initial
    forever #20 mclk = ~mclk;
  initial
  begin
    #1.7;
    forever #3 req_clk = ~req_clk;
  end
  // ----------------------------------------------------------------
  // Design and memory
  // ----------------------------------------------------------------
  bus_cycle_seq i_bus_cycle_seq (.mclk(mclk), .req_clk(req_clk), .resetn(resetn),
    .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_high_byte(req_high_byte), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cfg_ab_len(cfg_ab_len),
    .cfg_ab_ext(cfg_ab_ext), .cfg_c_len(cfg_c_len), .cfg_d_len(cfg_d_len),
    .cfg_e_len(cfg_e_len), .cfg_f_len(cfg_f_len), .cfg_mux(cfg_mux),
    .cfg_rdy_en(cfg_rdy_en), .cfg_rdy_pol(cfg_rdy_pol), .cfg_rdy_async(cfg_rdy_async),
    .bus_reference_clock_en(bus_reference_clock_en), .ready_pin(ready_pin), .separate_data_lines_i(sd_i),
    .separate_data_lines_o(sd_o), .separate_data_lines_oe_n(sd_oe_n),
    .shared_addr_data_lines_i(ad_i), .shared_addr_data_lines_o(ad_o),
    .shared_addr_data_lines_oe_n(ad_oe_n), .separate_address_lines(sep_addr), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr_latch_en(addr_latch_en), .high_byte_enable_n(hbe_n),
    .bus_reference_clock(ref_clk), .clk_drv_oe_n(drv_oe_n));
  ext_mem_model i_ext_mem_model (.mclk(mclk), .mux(cfg_mux[req_cs]),
    .rdy_pol(cfg_rdy_pol[req_cs]), .rdy_wait(mdl_wait), .rd_n(rd_n), .wr_n(wr_n),
    .addr_latch_en(addr_latch_en), .separate_address_lines(sep_addr),
    .separate_data_lines_o(sd_o), .shared_addr_data_lines_o(ad_o),
    .separate_data_lines_i(sd_i), .shared_addr_data_lines_i(ad_i), .ready_pin(ready_pin));
  // Bus monitor: lead is chip select low before the first strobe
  always @(posedge mclk)
  begin
    if (cs_n !== 4'hf)
    begin
      cs_len++;
      cs_seen = cs_n;
      if (rd_n && wr_n && stb_len == 0)
        pre_len++;
    end
    if (!rd_n || !wr_n)
      stb_len++;
    if (addr_latch_en)
      ale_len++;
    if (!hbe_n)
      hb_len++;
    if (!sd_oe_n)
      sd_len++;
    if (!ad_oe_n)
      ad_len++;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Program one chip select's phases, between cycles only
  task automatic set_cs(input int i, ab, ext, c, d, e, f, input logic mx, en, pol, asy);
    @(negedge mclk);
    ab_a[i] = ab; ext_a[i] = ext; c_a[i] = c; d_a[i] = d; e_a[i] = e; f_a[i] = f;
    cfg_ab_len[i] = ab[0]; cfg_ab_ext[2*i+:2] = ext[1:0]; cfg_c_len[2*i+:2] = c[1:0];
    cfg_d_len[i] = d[0]; cfg_e_len[5*i+:5] = e[4:0]; cfg_f_len[2*i+:2] = f[1:0];
    cfg_mux[i] = mx; cfg_rdy_en[i] = en; cfg_rdy_pol[i] = pol; cfg_rdy_async[i] = asy;
  endtask
  // One request, then the bus shape and read data are compared
  task automatic run(input logic wr, input logic [1:0] cs, input logic [23:0] a,
    input logic [15:0] wd, input logic hb, input logic chg, input logic [15:0] exp_rd);
    int n;
    int ab;
    n = 0;
    ab = 1 + ab_a[cs] + (chg ? ext_a[cs] : 0);
    cs_len = 0; pre_len = 0; stb_len = 0; ale_len = 0; hb_len = 0;
    sd_len = 0; ad_len = 0;
    @(negedge req_clk);
    req_valid = 1'b1; req_write = wr; req_cs = cs; req_addr = a; req_wdata = wd;
    req_high_byte = hb;
    do
    begin
      @(posedge req_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 100);
    // Request never taken: count it and go to the verdict
    if (req_ready !== 1'b1)
    begin
      fail_count++;
      stop_test();
    end
    @(negedge req_clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 4000)
    begin
      @(negedge req_clk);
      n++;
    end
    if (n >= 4000)
    begin
      fail_count++;
      stop_test();
    end
    if (!wr)
      check("rdata", rsp_rdata, exp_rd);
    check("lead", pre_len, ab + c_a[cs] + d_a[cs]);
    if (!cfg_rdy_en[cs])
      check("strobe", stb_len, e_a[cs] + 1);
    check("cs_len", cs_len, ab + c_a[cs] + d_a[cs] + stb_len + f_a[cs]);
    check("cs_sel", cs_seen, 4'(~(4'h1 << cs)));
    check("ale", ale_len, cfg_mux[cs] ? ab : 0);
    check("hbe", hb_len, hb ? cs_len : 0);
    check("addr", sep_addr, a);
    check("sd_drv", sd_len, (wr && !cfg_mux[cs]) ? d_a[cs] + stb_len + f_a[cs] : 0);
    check("ad_drv", ad_len, !cfg_mux[cs] ? 0 : (wr ? cs_len : ab + c_a[cs]));
    repeat (2) @(negedge mclk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("rst_cs", {cs_n, rd_n, wr_n, addr_latch_en, req_ready}, 8'hfd);
    resetn = 1'b1;
    set_cs(0, 0, 2, 1, 1, 2, 1, 1'b0, 1'b0, 1'b1, 1'b0);
    set_cs(1, 1, 3, 3, 0, 31, 3, 1'b0, 1'b0, 1'b1, 1'b0);
    set_cs(2, 1, 1, 0, 1, 0, 0, 1'b1, 1'b0, 1'b1, 1'b0);
    set_cs(3, 0, 0, 0, 0, 0, 2, 1'b0, 1'b1, 1'b1, 1'b0);
    // Demux write then reads, window changes add the extension
    run(1'b1, 2'h0, 24'h7a0005, 16'h1234, 1'b1, 1'b1, 16'h0000);
    run(1'b0, 2'h0, 24'h7a0005, 16'h0000, 1'b0, 1'b0, 16'h1234);
    run(1'b0, 2'h1, 24'h12340c, 16'h0000, 1'b1, 1'b1, 16'ha50c);
    run(1'b0, 2'h0, 24'h7a0005, 16'h0000, 1'b0, 1'b1, 16'h1234);
    $display("demux test done");
    // Multiplexed write and read back through the shared lines
    run(1'b1, 2'h2, 24'h000009, 16'hbeef, 1'b0, 1'b1, 16'h0000);
    run(1'b0, 2'h2, 24'h000009, 16'h0000, 1'b0, 1'b0, 16'hbeef);
    $display("mux test done");
    // Ready: sync active high, active low, then async must be slower
    run(1'b0, 2'h3, 24'h000005, 16'h0000, 1'b0, 1'b1, 16'h1234);
    stb_sync = stb_len;
    check("wait", stb_len > 1, 1'b1);
    set_cs(3, 0, 0, 0, 0, 0, 2, 1'b0, 1'b1, 1'b0, 1'b0);
    run(1'b0, 2'h3, 24'h000005, 16'h0000, 1'b0, 1'b0, 16'h1234);
    check("pol", stb_len, stb_sync);
    set_cs(3, 0, 0, 0, 0, 0, 2, 1'b0, 1'b1, 1'b0, 1'b1);
    run(1'b0, 2'h3, 24'h000005, 16'h0000, 1'b0, 1'b0, 16'h1234);
    check("async", stb_len > stb_sync, 1'b1);
    $display("ready test done");
    // Reference clock follows the system clock only when enabled
    check("clk_off", {ref_clk, drv_oe_n}, 2'h1);
    bus_reference_clock_en = 1'b1;
    repeat (3) @(posedge mclk);
    #10;
    check("clk_hi", {ref_clk, drv_oe_n}, 2'h2);
    @(negedge mclk);
    #10;
    check("clk_lo", {ref_clk, drv_oe_n}, 2'h0);
    $display("clock test done");
    stop_test();
  end
endmodule
`default_nettype wire
